// ### design/pisc_pkg.sv
// Package of constants and types for the package idle state controller
package pisc_pkg;
   localparam int clk_mhz = 50;
   localparam int freq_settle_ns = 2000;
   localparam logic [15:0] freq_settle_cycles =
      16'((freq_settle_ns * clk_mhz + 999) / 1000);
   localparam logic [3:0] addr_ctrl = 4'h0;
   localparam logic [3:0] addr_state = 4'h1;
   localparam logic [3:0] addr_card_flag = 4'h2;
   localparam logic [3:0] addr_host_flag = 4'h3;
   localparam logic [3:0] addr_wake_timer = 4'h4;
   localparam logic [3:0] addr_irq_status = 4'h5;
   localparam logic [3:0] addr_irq_mask = 4'h6;
   localparam logic [3:0] addr_tsc_lo = 4'h7;
   localparam logic [3:0] addr_local_irq_ctrl_timer = 4'h8;
   localparam logic [3:0] addr_etc_lo = 4'h9;
   localparam logic [3:0] addr_freq = 4'ha;
   localparam int ctrl_light_bit = 0;
   localparam int ctrl_deep_bit = 1;
   localparam int ctrl_off_bit = 2;
   localparam int ctrl_wake_bit = 3;
   localparam int irq_freq_bit = 0;
   localparam int irq_timer_bit = 1;
   localparam int irq_pcie_bit = 2;
   localparam int irq_timeout_bit = 3;
   localparam logic [31:0] flag_reset = 32'h0;
   localparam logic [3:0] irq_mask_reset = 4'h0;
   localparam logic [31:0] unmapped_data = 32'h0;

   typedef enum logic [1:0] {
      pisc_active,
      pisc_light,
      pisc_deep,
      pisc_off
   } pisc_state_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pisc_bus_s;
endpackage : pisc_pkg

// ### design/pisc_counter.sv
// Freezable free counter with reset pulse
module pisc_counter
   import pisc_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic run, // Advance when high
   input wire logic clear, // Return to zero
   input wire logic load, // Software load
   input wire logic [31:0] load_val, // Load value
   output logic [31:0] count // Counter value
);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count <= 32'h0;
      end else if (clear) begin
         count <= 32'h0;
      end else if (load) begin
         count <= load_val;
      end else if (run) begin
         count <= count + 32'h1;
      end
   end
endmodule : pisc_counter

// ### design/pisc_ctrl.sv
// Package idle state controller top
//
// The register addresses and the strobed register port were decided locally.
module pisc_ctrl
   import pisc_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic [3:0] addr, // Register address
   input wire logic [31:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [31:0] rdata, // Read data, cycle after rd
   input wire logic pcie_traffic, // PCIe traffic arrives, async
   input wire logic host_deep_req, // Host asks deep idle, async
   input wire logic host_off_req, // Host asks off idle, async
   input wire logic host_wake, // Host wake request, async
   input wire logic freq_reached, // Core clock at target, async
   output logic [1:0] pkg_state, // Current package state
   output logic pcie_timeout, // Traffic refused while deep/off
   output logic core_state_lost, // Core and uncore state lost
   output logic irq // Interrupt, level
);
   pisc_bus_s bus;
   pisc_state_e state;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic pcie_s;
   logic deep_s;
   logic off_s;
   logic hwake_s;
   logic freq_s;
   logic [31:0] card_pm_state_flag;
   logic [31:0] host_pm_state_flag;
   logic [31:0] idle_wake_timer;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] irq_set;
   logic [31:0] timestamp_counter;
   logic [31:0] local_irq_ctrl_timer;
   logic [31:0] elapsed_time_counter;
   logic freq_wait;
   logic [15:0] settle;
   logic timer_expired;
   logic idle;
   logic clear_timers;
   logic light_req;
   logic [31:0] next_rdata;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Two-stage synchronisers for external events
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {pcie_traffic, host_deep_req, host_off_req, host_wake};
         sync2 <= sync1;
      end
   end

   logic freq_m;
   logic freq_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         freq_m <= 1'b0;
         freq_q <= 1'b0;
      end else begin
         freq_m <= freq_reached;
         freq_q <= freq_m;
      end
   end

   assign pcie_s = sync2[3];
   assign deep_s = sync2[2];
   assign off_s = sync2[1];
   assign hwake_s = sync2[0];
   assign freq_s = freq_q;
   assign idle = (state != pisc_active);
   assign light_req = bus.wr && (bus.addr == addr_ctrl) &&
      bus.wdata[ctrl_light_bit];
   assign timer_expired = (state == pisc_light) &&
      (idle_wake_timer == 32'h1);

   // Package idle state machine
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= pisc_active;
      end else begin
         case (state)
            pisc_active: begin
               if (light_req) begin
                  state <= pisc_light;
               end else if (off_s) begin
                  state <= pisc_off;
               end
            end
            pisc_light: begin
               if (timer_expired || pcie_s || hwake_s) begin
                  state <= pisc_active;
               end else if (off_s) begin
                  state <= pisc_off;
               end else if (deep_s) begin
                  state <= pisc_deep;
               end
            end
            pisc_deep: begin
               if (hwake_s) begin
                  state <= pisc_active;
               end else if (off_s) begin
                  state <= pisc_off;
               end
            end
            pisc_off: begin
               if (hwake_s) begin
                  state <= pisc_active;
               end
            end
            default: begin
               state <= pisc_active;
            end
         endcase
      end
   end

   // Clear timers when entering off idle
   assign clear_timers = (state != pisc_off) && (
      ((state == pisc_light) && !(timer_expired || pcie_s || hwake_s) &&
       off_s) ||
      ((state == pisc_deep) && !hwake_s && off_s) ||
      ((state == pisc_active) && !light_req && off_s));

   // Wake timer counts down only in light idle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         idle_wake_timer <= 32'h0;
      end else if (bus.wr && bus.addr == addr_wake_timer) begin
         idle_wake_timer <= bus.wdata;
      end else if (state == pisc_light && idle_wake_timer != 32'h0) begin
         idle_wake_timer <= idle_wake_timer - 32'h1;
      end
   end

   // Frequency settle wait after light idle exit
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         freq_wait <= 1'b0;
         settle <= 16'h0;
      end else if (state == pisc_light && !idle_next_light()) begin
         freq_wait <= 1'b1;
         settle <= freq_settle_cycles;
      end else if (freq_wait && freq_s && settle == 16'h0) begin
         freq_wait <= 1'b0;
      end else if (freq_wait && settle != 16'h0) begin
         settle <= settle - 16'h1;
      end
   end

   function automatic logic idle_next_light();
      idle_next_light = !(timer_expired || pcie_s || hwake_s ||
         off_s || deep_s);
   endfunction : idle_next_light

   pisc_counter u_tsc (
      .clock(clock),
      .nrst(nrst),
      .run(!idle),
      .clear(clear_timers),
      .load(bus.wr && bus.addr == addr_tsc_lo),
      .load_val(bus.wdata),
      .count(timestamp_counter)
   );

   pisc_counter u_local_irq_ctrl_timer (
      .clock(clock),
      .nrst(nrst),
      .run(!idle),
      .clear(clear_timers),
      .load(bus.wr && bus.addr == addr_local_irq_ctrl_timer),
      .load_val(bus.wdata),
      .count(local_irq_ctrl_timer)
   );

   pisc_counter u_etc (
      .clock(clock),
      .nrst(nrst),
      .run(1'b1),
      .clear(1'b0),
      .load(1'b0),
      .load_val(bus.wdata),
      .count(elapsed_time_counter)
   );

   // State flags, writable in every state
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         card_pm_state_flag <= flag_reset;
         host_pm_state_flag <= flag_reset;
      end else begin
         if (bus.wr && bus.addr == addr_card_flag) begin
            card_pm_state_flag <= bus.wdata;
         end
         if (bus.wr && bus.addr == addr_host_flag) begin
            host_pm_state_flag <= bus.wdata;
         end
      end
   end

   // Interrupt events; set wins over clear
   always_comb begin
      irq_set = 4'h0;
      irq_set[irq_freq_bit] = freq_wait && freq_s && settle == 16'h0;
      irq_set[irq_timer_bit] = timer_expired;
      irq_set[irq_pcie_bit] = pcie_s && state == pisc_light;
      irq_set[irq_timeout_bit] = pcie_s &&
         (state == pisc_deep || state == pisc_off);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_status <= 4'h0;
      end else if (bus.wr && bus.addr == addr_irq_status) begin
         irq_status <= (irq_status & ~bus.wdata[3:0]) | irq_set;
      end else begin
         irq_status <= irq_status | irq_set;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_mask <= irq_mask_reset;
      end else if (bus.wr && bus.addr == addr_irq_mask) begin
         irq_mask <= bus.wdata[3:0];
      end
   end

   // Read mux
   always_comb begin
      case (bus.addr)
         addr_state: next_rdata = {30'h0, state};
         addr_card_flag: next_rdata = card_pm_state_flag;
         addr_host_flag: next_rdata = host_pm_state_flag;
         addr_wake_timer: next_rdata = idle_wake_timer;
         addr_irq_status: next_rdata = {28'h0, irq_status};
         addr_irq_mask: next_rdata = {28'h0, irq_mask};
         addr_tsc_lo: next_rdata = timestamp_counter;
         addr_local_irq_ctrl_timer: next_rdata = local_irq_ctrl_timer;
         addr_etc_lo: next_rdata = elapsed_time_counter;
         addr_freq: next_rdata = {31'h0, freq_wait};
         default: next_rdata = unmapped_data;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0;
      end else if (bus.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 32'h0;
      end
   end

   // Registered outputs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pkg_state <= 2'h0;
         pcie_timeout <= 1'b0;
         core_state_lost <= 1'b0;
         irq <= 1'b0;
      end else begin
         pkg_state <= state;
         pcie_timeout <= irq_set[irq_timeout_bit];
         core_state_lost <= (state == pisc_off);
         irq <= |(irq_status & irq_mask);
      end
   end

   light_stop_a: assert property (@(posedge clock) disable iff (!nrst)
      state != pisc_active && !clear_timers &&
      !(bus.wr && bus.addr == addr_local_irq_ctrl_timer) |=>
      local_irq_ctrl_timer == $past(local_irq_ctrl_timer))
      else $error("local timer advanced while idle");
   tsc_freeze_a: assert property (@(posedge clock) disable iff (!nrst)
      (state == pisc_light || state == pisc_deep) && !clear_timers &&
      !(bus.wr && bus.addr == addr_tsc_lo)
      |=> timestamp_counter == $past(timestamp_counter))
      else $error("timestamp moved while idle");
   timer_exit_a: assert property (@(posedge clock) disable iff (!nrst)
      timer_expired |=> state == pisc_active)
      else $error("wake timer did not exit light idle");
   pcie_light_a: assert property (@(posedge clock) disable iff (!nrst)
      state == pisc_light && pcie_s |=> state == pisc_active)
      else $error("traffic did not wake light idle");
   pcie_deep_a: assert property (@(posedge clock) disable iff (!nrst)
      state == pisc_deep && pcie_s && !hwake_s |=> state != pisc_active)
      else $error("traffic woke deep idle");
   no_auto_deep_a: assert property (@(posedge clock) disable iff (!nrst)
      state == pisc_light && !deep_s && !off_s |=>
      state inside {pisc_light, pisc_active})
      else $error("light idle deepened on its own");
   off_reset_a: assert property (@(posedge clock) disable iff (!nrst)
      clear_timers |=> timestamp_counter == 32'h0)
      else $error("timestamp not reset for off idle");
   freq_irq_a: assert property (@(posedge clock) disable iff (!nrst)
      irq_set[irq_freq_bit] |=> irq_status[irq_freq_bit])
      else $error("frequency interrupt lost");
   etc_runs_a: assert property (@(posedge clock) disable iff (!nrst)
      nrst |=> elapsed_time_counter == $past(elapsed_time_counter)
      + 32'h1)
      else $error("elapsed counter stalled");
   flag_write_a: assert property (@(posedge clock) disable iff (!nrst)
      bus.wr && bus.addr == addr_host_flag |=>
      host_pm_state_flag == $past(bus.wdata))
      else $error("host flag write lost");

   light_wake_c: cover property (@(posedge clock) disable iff (!nrst)
      state == pisc_light ##1 state == pisc_active);
   deep_c: cover property (@(posedge clock) disable iff (!nrst)
      state == pisc_deep);
   off_c: cover property (@(posedge clock) disable iff (!nrst)
      state == pisc_off ##1 state == pisc_active);
endmodule : pisc_ctrl

// ### test/pisc_host_model.sv
// Host power driver model driving the card's link-side inputs
module pisc_host_model
   import pisc_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic [1:0] pkg_state, // Card package state
   output logic pcie_traffic, // Traffic toward the card
   output logic host_deep_req, // Deep idle request
   output logic host_off_req, // Off idle request
   output logic host_wake // Wake request
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {pcie_traffic, host_deep_req, host_off_req, host_wake} = 4'h0;
   end

   // Level held well past the input synchronizers, then dropped
   task automatic pulse(input int which);
      @(posedge clock);
      case (which)
         0: pcie_traffic <= 1'b1;
         1: host_deep_req <= 1'b1;
         2: host_off_req <= 1'b1;
         default: host_wake <= 1'b1;
      endcase
      repeat (6) @(posedge clock);
      {pcie_traffic, host_deep_req, host_off_req, host_wake} <= 4'h0;
   endtask : pulse

   // Deeper states only by explicit host action: deep from light idle, off after a wake from light idle to active
   task automatic go_deeper(input bit off);
      if (pkg_state == pisc_light) begin
         if (off) pulse(3);
         pulse(off ? 2 : 1);
      end
   endtask : go_deeper

   // Routed traffic wakes a deep or off card first
   task automatic send(input bit routed);
      if (routed && pkg_state inside {pisc_deep, pisc_off}) pulse(3);
      pulse(0);
   endtask : send
endmodule : pisc_host_model

// ### test/testbench.sv
// Self-checking bench for the package idle state controller
module testbench
   import pisc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, nrst, wr, rd, freq_reached, pcie_timeout, core_state_lost, irq;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, seed, d, t1, t2, l1, e1, e2;
   logic [1:0] pkg_state;
   logic pcie_traffic, host_deep_req, host_off_req, host_wake;
   int n_errors = 0, num_checks = 0, n_to = 0, bad, v;
   logic [3:0] zero_regs[6] = '{addr_state, addr_card_flag, addr_host_flag,
      addr_irq_status, addr_irq_mask, 4'hb};

   pisc_ctrl pisc_ctrl_i (.clock(clock), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pcie_traffic(pcie_traffic), .host_deep_req(host_deep_req),
      .host_off_req(host_off_req), .host_wake(host_wake),
      .freq_reached(freq_reached), .pkg_state(pkg_state),
      .pcie_timeout(pcie_timeout), .core_state_lost(core_state_lost),
      .irq(irq));
   pisc_host_model pisc_host_model_i (.clock(clock), .pkg_state(pkg_state),
      .pcie_traffic(pcie_traffic), .host_deep_req(host_deep_req),
      .host_off_req(host_off_req), .host_wake(host_wake));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(posedge clock) if (pcie_timeout === 1'b1) n_to++;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [31:0] bit_of(input int b);
      return 32'h1 << b;
   endfunction : bit_of

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] dv);
      @(posedge clock);
      addr <= a;
      wdata <= dv;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] dv);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 dv = rdata;
   endtask : rd_reg

   task automatic wait_state(input logic [1:0] s);
      int n;
      n = 0;
      while (pkg_state !== s && n < 300) begin
         @(posedge clock);
         #1 n++;
      end
      check("pkg_state", {30'h0, s}, {30'h0, pkg_state});
   endtask : wait_state

   task automatic enter_light(input logic [31:0] tv);
      wr_reg(addr_irq_status, 32'hf);
      wr_reg(addr_wake_timer, tv);
      rd_reg(addr_etc_lo, e1);
      wr_reg(addr_card_flag, 32'(pisc_light));
      wr_reg(addr_ctrl, bit_of(ctrl_light_bit));
      wait_state(pisc_light);
   endtask : enter_light

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (30000) @(posedge clock);
      n_errors++;
      wrap_up();
   end

   initial begin
      {nrst, wr, rd, freq_reached, addr, wdata} = '0;
      seed = 32'h70e751d1;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      foreach (zero_regs[i]) begin
         rd_reg(zero_regs[i], d);
         check("reset value", 32'h0, d);
      end
      check("irq after reset", 32'h0, {31'h0, irq});
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr_reg(addr_card_flag, seed);
         wr_reg(addr_host_flag, ~seed);
         rd_reg(addr_card_flag, d);
         check("card flag", seed, d);
         rd_reg(addr_host_flag, d);
         check("host flag", ~seed, d);
      end
      $display("test flags done");
      seed = lfsr(seed);
      v = 60 + int'(seed[3:0]);
      enter_light(32'(v));
      rd_reg(addr_tsc_lo, t1);
      rd_reg(addr_local_irq_ctrl_timer, l1);
      rd_reg(addr_etc_lo, e1);
      wr_reg(addr_card_flag, seed);
      rd_reg(addr_card_flag, d);
      check("flag in idle", seed, d);
      rd_reg(addr_tsc_lo, t2);
      check("tsc frozen", t1, t2);
      rd_reg(addr_local_irq_ctrl_timer, d);
      check("local timer frozen", l1, d);
      rd_reg(addr_etc_lo, e2);
      check("etc runs", 32'h1, {31'h0, e2 > e1});
      wait_state(pisc_active);
      rd_reg(addr_irq_status, d);
      check("timer status", bit_of(irq_timer_bit), d & 32'h2);
      wr_reg(addr_irq_mask, bit_of(irq_freq_bit));
      @(posedge clock);
      freq_reached <= 1'b1;
      v = 0;
      while (irq !== 1'b1 && v < 400) begin
         @(posedge clock);
         #1 v++;
      end
      check("freq irq delay", 32'h1, {31'h0, v >= int'(freq_settle_cycles)
         - 4 && v <= int'(freq_settle_cycles) + 10});
      wr_reg(addr_irq_mask, 32'h0);
      @(posedge clock);
      #1 check("irq masked", 32'h0, {31'h0, irq});
      freq_reached <= 1'b0;
      wr_reg(addr_irq_status, 32'hf);
      rd_reg(addr_irq_status, d);
      check("status cleared", 32'h0, d);
      $display("test timer exit done");
      enter_light(32'hffff);
      bad = 0;
      repeat (60) @(posedge clock) bad += (pkg_state !== pisc_light);
      check("stays light", 32'h0, 32'(bad));
      pisc_host_model_i.send(1'b0);
      wait_state(pisc_active);
      rd_reg(addr_irq_status, d);
      check("pcie status", bit_of(irq_pcie_bit), d & 32'h4);
      rd_reg(addr_etc_lo, e2);
      check("etc after wake", 32'h1, {31'h0, e2 > e1});
      wr_reg(addr_card_flag, 32'(pisc_active));
      $display("test pcie wake done");
      enter_light(32'hffff);
      pisc_host_model_i.go_deeper(1'b0);
      wait_state(pisc_deep);
      rd_reg(addr_tsc_lo, t1);
      v = n_to;
      pisc_host_model_i.send(1'b0);
      repeat (5) @(posedge clock);
      // Timeout level lasts as long as synced traffic: six cycles
      check("timeout pulse", 32'h6, 32'(n_to - v));
      check("still deep", 32'(pisc_deep), {30'h0, pkg_state});
      check("state kept", 32'h0, {31'h0, core_state_lost});
      repeat (100) @(posedge clock);
      pisc_host_model_i.send(1'b1);
      wait_state(pisc_active);
      rd_reg(addr_tsc_lo, t2);
      check("tsc resumes", 32'h1, {31'h0, t2 > t1 && t2 - t1 < 60});
      $display("test deep idle done");
      wr_reg(addr_tsc_lo, 32'h10000);
      wr_reg(addr_local_irq_ctrl_timer, 32'h10000);
      enter_light(32'hffff);
      pisc_host_model_i.go_deeper(1'b1);
      wait_state(pisc_off);
      check("state lost", 32'h1, {31'h0, core_state_lost});
      pisc_host_model_i.pulse(3);
      wait_state(pisc_active);
      rd_reg(addr_tsc_lo, d);
      check("tsc reset", 32'h1, {31'h0, d < 32'h100});
      rd_reg(addr_local_irq_ctrl_timer, d);
      check("local timer reset", 32'h1, {31'h0, d < 32'h100});
      $display("test off idle done");
      wrap_up();
   end
endmodule : testbench
